// ### common/pps_pkg.sv
package pps_pkg;

    // Pin map: 8 bits per port, three ports
    localparam int PORT_W = 8;
    localparam int NPORT = 3;
    localparam int NPIN = PORT_W * NPORT;
    localparam int OSEL_W = 6;
    localparam int ISEL_W = 5;
    localparam int NSRC = 64;
    localparam int NIN = 39;

    // Input select field positions
    localparam int ISEL_PORT_LSB = 3;
    localparam int ISEL_PIN_LSB = 0;

    // Port field codes
    localparam logic [1:0] PORT_A = 2'h0;
    localparam logic [1:0] PORT_B = 2'h1;
    localparam logic [1:0] PORT_C = 2'h2;

    // Output select codes given for the window signals
    localparam logic [5:0] OSEL_LATCH = 6'h00;
    localparam logic [5:0] OSEL_COMPARATOR_ONE = 6'h11;
    localparam logic [5:0] OSEL_ADC_GUARD_A = 6'h1f;
    localparam logic [5:0] OSEL_ADC_GUARD_B = 6'h20;
    localparam logic [5:0] OSEL_RESET = 6'h00;

    // Input indices with special handling
    localparam int IN_EXT_INT = 0;
    localparam int IN_SERIAL_RX = 35;
    localparam int IN_SERIAL_CK = 36;
    localparam int IN_SYNC_CLK = 25;
    localparam int IN_SYNC_DAT = 26;

    // Inputs whose select register is shared with one of the above, and the two second sync port pairs
    localparam int IN_SERIAL_RX_PAIR = 34;
    localparam int IN_SYNC_CLK_PAIR = 24;
    localparam int IN_SYNC_DAT_PAIR = 27;
    localparam int IN_SYNC2_CLK = 30;
    localparam int IN_SYNC2_CLK_PAIR = 29;
    localparam int IN_SYNC2_DAT = 31;
    localparam int IN_SYNC2_DAT_PAIR = 32;

    typedef logic [ISEL_W-1:0] pps_isel_t;
    typedef logic [OSEL_W-1:0] pps_osel_t;

    // Per-pin direction and peripheral override bundle
    typedef struct packed {
        logic [NPIN-1:0] dir_in;
        logic [NPIN-1:0] ovr_en;
        logic [NPIN-1:0] ovr_drive_n;
    } pps_drv_s;

    // Power-on defaults of the input selects, 14/16-pin then 20-pin
    localparam logic [ISEL_W*NIN-1:0] ISEL_RST_SMALL = {
        5'h04, 5'h10, 5'h14, 5'h15, 5'h15, 5'h00, 5'h15, 5'h15,
        5'h14, 5'h14, 5'h13, 5'h11, 5'h11, 5'h10, 5'h10, 5'h12,
        5'h05, 5'h11, 5'h14, 5'h13, 5'h02, 5'h02, 5'h04, 5'h02,
        5'h13, 5'h15, 5'h01, 5'h15, 5'h12, 5'h12, 5'h13, 5'h10,
        5'h11, 5'h14, 5'h15, 5'h05, 5'h04, 5'h05, 5'h02};
    localparam logic [ISEL_W*NIN-1:0] ISEL_RST_LARGE = {
        5'h04, 5'h10, 5'h0f, 5'h0d, 5'h0d, 5'h01, 5'h0d, 5'h0d,
        5'h0f, 5'h0f, 5'h16, 5'h0c, 5'h0c, 5'h0e, 5'h0e, 5'h12,
        5'h0d, 5'h0c, 5'h13, 5'h02, 5'h02, 5'h02, 5'h04, 5'h02,
        5'h13, 5'h15, 5'h01, 5'h15, 5'h12, 5'h12, 5'h13, 5'h10,
        5'h11, 5'h14, 5'h15, 5'h05, 5'h04, 5'h05, 5'h02};

endpackage : pps_pkg

// ### src/pps_mux.sv
// Behaviour
// - Each pin has its own output select choosing the source on it.
// - All pins decode output select codes through one shared table.
// - The pin direction bit normally owns the pin driver enable.
// - Sync serial and I2C override the direction bit when active.
// - Codes 0x1f, 0x20 and 0x11 route guard A, guard B, comparator 1.
// - Input selects are 5-bit codes with package-specific defaults.
// - Sync serial data/clock and I2C lines share one select each.
// - Every input owns its select except the five shared pairs; many may pick the same pin.
// - Port reads return the pin level whatever the selection.
// - Only power-on reset restores defaults; other resets do not.
module pps_mux #(
    parameter bit LARGE_PKG = 1'b1
) (
    input wire logic I_CLK, // System clock
    input wire logic I_RST, // Power-on reset, async high
    input wire logic I_CFG_WE, // Select write strobe
    input wire logic I_CFG_IS_OUT, // 1 output select, 0 input select
    input wire logic [5:0] I_CFG_IDX, // Pin or input index
    input wire logic [5:0] I_CFG_DATA, // Select code
    input wire logic [pps_pkg::NPIN-1:0] I_PIN, // Pin levels
    input wire logic [pps_pkg::NPIN-1:0] I_LAT, // Port latch values
    input wire logic [pps_pkg::NPIN-1:0] I_DIR_IN, // Direction, 1 input
    input wire logic [pps_pkg::NSRC-1:0] I_PERIPH_OUT, // Source signals
    input wire logic I_SERIAL_SYNC, // Serial transceiver sync mode
    input wire logic I_SERIAL_DT_OE, // Sync data drive, 1 drive
    input wire logic I_SERIAL_CK_OE, // Sync clock drive, 1 drive
    input wire logic I_SYNC_I2C, // Sync port in I2C mode
    input wire logic I_I2C_SCL_LOW, // I2C pulls clock low
    input wire logic I_I2C_SDA_LOW, // I2C pulls data low
    output logic [pps_pkg::NPIN-1:0] O_PIN_OUT, // Pin output value
    output logic [pps_pkg::NPIN-1:0] O_PIN_OE_N, // Pin enable, low drives
    output logic [pps_pkg::NPIN-1:0] O_PORT_READ, // Port read value
    output logic [pps_pkg::NIN-1:0] O_PERIPH_IN // Routed inputs
);
    import pps_pkg::*;

    pps_osel_t osel_r [NPIN];
    pps_osel_t osel_nxt [NPIN];
    pps_isel_t isel_r [NIN];
    pps_isel_t isel_nxt [NIN];
    logic [NPIN-1:0] pin_m_r;
    logic [NPIN-1:0] pin_s_r;
    logic [NPIN-1:0] out_nxt;
    logic [NPIN-1:0] oe_n_nxt;
    logic [NIN-1:0] in_nxt;
    logic [NPIN-1:0] out_r;
    logic [NPIN-1:0] oe_n_r;
    logic [NIN-1:0] in_r;
    pps_drv_s drv;

    // Shared output code table; code zero gives the port latch
    function automatic logic src_sel(input pps_osel_t code,
                                     input logic lat,
                                     input logic [NSRC-1:0] src);
        if (code == OSEL_LATCH) begin
            return lat;
        end
        return src[code];
    endfunction : src_sel

    // Input code to flat pin index
    function automatic int unsigned pin_idx(input pps_isel_t code);
        logic [1:0] port;
        port = code[ISEL_W-1:ISEL_PORT_LSB];
        // Port code 3 names no port, so it routes nothing
        if (port > PORT_C) begin
            return NPIN;
        end
        return port * PORT_W + code[ISEL_PORT_LSB-1:ISEL_PIN_LSB];
    endfunction : pin_idx

    // Find pins picked by a shared bidirectional select
    function automatic logic [NPIN-1:0] pin_onehot(input pps_isel_t code);
        logic [NPIN-1:0] v;
        int unsigned k;
        v = '0;
        k = pin_idx(code);
        if (k < NPIN) begin
            v[k] = 1'b1;
        end
        return v;
    endfunction : pin_onehot

    // Partner of an input whose select register is shared with another
    function automatic int isel_mate(input int i);
        int m;
        case (i)
            IN_SYNC_CLK: m = IN_SYNC_CLK_PAIR;
            IN_SYNC_CLK_PAIR: m = IN_SYNC_CLK;
            IN_SYNC_DAT: m = IN_SYNC_DAT_PAIR;
            IN_SYNC_DAT_PAIR: m = IN_SYNC_DAT;
            IN_SYNC2_CLK: m = IN_SYNC2_CLK_PAIR;
            IN_SYNC2_CLK_PAIR: m = IN_SYNC2_CLK;
            IN_SYNC2_DAT: m = IN_SYNC2_DAT_PAIR;
            IN_SYNC2_DAT_PAIR: m = IN_SYNC2_DAT;
            IN_SERIAL_RX: m = IN_SERIAL_RX_PAIR;
            IN_SERIAL_RX_PAIR: m = IN_SERIAL_RX;
            default: m = i;
        endcase
        return m;
    endfunction : isel_mate

    // A select write lands on an input or on the input sharing its select
    function automatic logic isel_hit(input int i, input logic [5:0] idx);
        return idx == 6'(i) || idx == 6'(isel_mate(i));
    endfunction : isel_hit

    // Select register update; a write to either copy of a shared select
    // lands in both, so the pair can never point at different pins
    always_comb begin
        for (int p = 0; p < NPIN; p++) begin
            osel_nxt[p] = osel_r[p];
            if (I_CFG_WE && I_CFG_IS_OUT && I_CFG_IDX == 6'(p)) begin
                osel_nxt[p] = I_CFG_DATA;
            end
        end
        for (int i = 0; i < NIN; i++) begin
            isel_nxt[i] = isel_r[i];
            if (I_CFG_WE && !I_CFG_IS_OUT && isel_hit(i, I_CFG_IDX)) begin
                isel_nxt[i] = I_CFG_DATA[ISEL_W-1:0];
            end
        end
    end

    // Only power-on reset reaches the selects; other reset sources are not
    // wired here, so the selects live through them
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            for (int p = 0; p < NPIN; p++) begin
                osel_r[p] <= OSEL_RESET;
            end
            for (int i = 0; i < NIN; i++) begin
                isel_r[i] <= LARGE_PKG ? ISEL_RST_LARGE[i*ISEL_W +: ISEL_W]
                                       : ISEL_RST_SMALL[i*ISEL_W +: ISEL_W];
            end
        end else begin
            osel_r <= osel_nxt;
            isel_r <= isel_nxt;
        end
    end

    // Pin synchroniser: pins move with no relation to the clock, so only
    // the second stage is read by any logic
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            pin_m_r <= '0;
            pin_s_r <= '0;
        end else begin
            pin_m_r <= I_PIN;
            pin_s_r <= pin_m_r;
        end
    end

    // Peripheral driver overrides, aimed at the pins the shared selects name.
    // The override follows the input select on purpose: a bidirectional line
    // only works when its input and output name the same pin.
    always_comb begin
        logic [NPIN-1:0] dt_pin;
        logic [NPIN-1:0] ck_pin;
        logic [NPIN-1:0] scl_pin;
        logic [NPIN-1:0] sda_pin;
        dt_pin = pin_onehot(isel_r[IN_SERIAL_RX]);
        ck_pin = pin_onehot(isel_r[IN_SERIAL_CK]);
        scl_pin = pin_onehot(isel_r[IN_SYNC_CLK]);
        sda_pin = pin_onehot(isel_r[IN_SYNC_DAT]);
        // No override by default: the direction bits own the drivers
        drv.dir_in = I_DIR_IN;
        drv.ovr_en = '0;
        drv.ovr_drive_n = '0;
        if (I_SERIAL_SYNC) begin
            drv.ovr_en = dt_pin | ck_pin;
            drv.ovr_drive_n = (dt_pin & {NPIN{!I_SERIAL_DT_OE}})
                            | (ck_pin & {NPIN{!I_SERIAL_CK_OE}});
        end
        // I2C only pulls low; a released line floats to its pull-up
        if (I_SYNC_I2C) begin
            drv.ovr_en = drv.ovr_en | scl_pin | sda_pin;
            drv.ovr_drive_n = drv.ovr_drive_n
                            | (scl_pin & {NPIN{!I_I2C_SCL_LOW}})
                            | (sda_pin & {NPIN{!I_I2C_SDA_LOW}});
        end
    end

    // Output and input routing; code zero hands the pin back to its latch
    always_comb begin
        for (int p = 0; p < NPIN; p++) begin
            out_nxt[p] = src_sel(osel_r[p], I_LAT[p],
                                 I_PERIPH_OUT);
            oe_n_nxt[p] = drv.ovr_en[p] ? drv.ovr_drive_n[p]
                                        : drv.dir_in[p];
        end
        // An input on port code 3 reads a steady 0
        for (int i = 0; i < NIN; i++) begin
            int unsigned k;
            k = pin_idx(isel_r[i]);
            in_nxt[i] = (k < NPIN) ? pin_s_r[k] : 1'b0;
        end
    end

    // Output registers, so every pin and routed input leaves from a flop
    // and reset releases all pins undriven
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            out_r <= '0;
            oe_n_r <= '1;
            in_r <= '0;
        end else begin
            out_r <= out_nxt;
            oe_n_r <= oe_n_nxt;
            in_r <= in_nxt;
        end
    end

    assign O_PIN_OUT = out_r;
    assign O_PIN_OE_N = oe_n_r;
    assign O_PORT_READ = pin_s_r;
    assign O_PERIPH_IN = in_r;

endmodule : pps_mux

// ### verification/pps_mux_properties.sv
module pps_mux_chk (
    input wire logic I_CLK, I_RST, I_CFG_WE, I_CFG_IS_OUT, // Clock, controls
    input wire logic [5:0] I_CFG_IDX, I_CFG_DATA, // Select write
    input wire logic [23:0] I_PIN, I_LAT, I_DIR_IN, // Pin side
    input wire logic [63:0] I_PERIPH_OUT, // Sources
    input wire logic I_SERIAL_SYNC, I_SERIAL_DT_OE, I_SYNC_I2C, // Modes
    input wire logic I_I2C_SDA_LOW, // Data pull
    input wire logic [23:0] O_PIN_OUT, O_PIN_OE_N, O_PORT_READ, // Pin out
    input wire logic [38:0] O_PERIPH_IN // Routed
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    // Output path and pin driver ownership
    property p_rst;
        disable iff (1'b0) I_RST |=> O_PIN_OE_N == '1 && O_PIN_OUT == '0;
    endproperty
    property p_osel;
        logic [5:0] p, c;
        logic v;
        (I_CFG_WE && I_CFG_IS_OUT && I_CFG_IDX < 6'h18, p = I_CFG_IDX,
            c = I_CFG_DATA) ##1 (1'b1, v = c == 6'h00 ? I_LAT[p] :
            I_PERIPH_OUT[c]) |=> O_PIN_OUT[p] == v;
    endproperty
    property p_oe;
        !(I_SERIAL_SYNC || I_SYNC_I2C) |=> O_PIN_OE_N == $past(I_DIR_IN);
    endproperty
    property p_i2c;
        I_SYNC_I2C |=> O_PIN_OE_N[12] == !$past(I_I2C_SDA_LOW);
    endproperty
    property p_ser;
        I_SERIAL_SYNC |=> O_PIN_OE_N[13] == !$past(I_SERIAL_DT_OE);
    endproperty
    // Input path through the pin synchronisers
    property p_rd;
        ##2 O_PORT_READ == $past(I_PIN, 2);
    endproperty
    property p_int;
        ##3 O_PERIPH_IN[0] == $past(I_PIN[2], 3);
    endproperty
    // Two inputs parked on one pin, and the receive pair sharing a select
    property p_shr;
        O_PERIPH_IN[17] == O_PERIPH_IN[0];
    endproperty
    property p_pair;
        O_PERIPH_IN[35] == O_PERIPH_IN[34];
    endproperty
    a_rst: assert property (p_rst) else $error("reset outs");
    a_osel: assert property (p_osel) else $error("pin source");
    a_oe: assert property (p_oe) else $error("pin enable");
    a_i2c: assert property (p_i2c) else $error("data enable");
    a_ser: assert property (p_ser) else $error("sync enable");
    a_rd: assert property (p_rd) else $error("port read");
    a_int: assert property (p_int) else $error("input route");
    a_shr: assert property (p_shr) else $error("shared pin");
    a_pair: assert property (p_pair) else $error("shared select");
    c_out: cover property (I_CFG_WE && I_CFG_IS_OUT);
    c_in: cover property (I_CFG_WE && !I_CFG_IS_OUT);
    c_pull: cover property (I_SYNC_I2C && I_I2C_SDA_LOW);
endmodule : pps_mux_chk

// ### verification/pps_pin_model.sv
module pps_pin_model (
    input wire logic [23:0] i_out, // Driven value
    input wire logic [23:0] i_oe_n, // Low drives
    input wire logic [23:0] i_ext, // Outside level
    output logic [23:0] o_pin // Pin level
);
    timeunit 1ns;
    timeprecision 100ps;
    // Driven pins show the block, released pins the outside level
    assign o_pin = (i_out & ~i_oe_n) | (i_ext & i_oe_n);
endmodule : pps_pin_model

// ### verification/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {int i; logic v;} pps_note_s;
    logic clk = 1'b0, rst = 1'b1, we = 1'b0, iso = 1'b0, ss = 1'b0, b;
    logic dt = 1'b0, ck = 1'b0, i2c = 1'b0, scl = 1'b0, sda = 1'b0;
    logic [5:0] idx = 6'h00, dat = 6'h00, c;
    logic [5:0] cd [4] = '{6'h11, 6'h1f, 6'h20, 6'h00};
    logic [23:0] pin, pout, poe, prd, e, lat = 24'h000000;
    logic [23:0] dir = 24'h000000, ext = 24'h000000;
    logic [63:0] per = 64'h0;
    logic [38:0] pper;
    int bad_count = 0, cmp_count = 0, seed = 44;
    pps_note_s n, q[$];
    // Clock and the watched outputs as one flat vector
    always #2 clk = ~clk;
    wire [110:0] allo = {pper, prd, poe, pout};
    pps_mux dut_u (.I_CLK(clk), .I_RST(rst), .I_CFG_WE(we), .I_CFG_IS_OUT(iso),
        .I_CFG_IDX(idx), .I_CFG_DATA(dat), .I_PIN(pin), .I_LAT(lat),
        .I_DIR_IN(dir), .I_PERIPH_OUT(per), .I_SERIAL_SYNC(ss),
        .I_SERIAL_DT_OE(dt), .I_SERIAL_CK_OE(ck), .I_SYNC_I2C(i2c),
        .I_I2C_SCL_LOW(scl), .I_I2C_SDA_LOW(sda), .O_PIN_OUT(pout),
        .O_PIN_OE_N(poe), .O_PORT_READ(prd), .O_PERIPH_IN(pper));
    pps_pin_model pm_u (.i_out(pout), .i_oe_n(poe), .i_ext(ext), .o_pin(pin));
    task automatic wr(input logic o, input logic [5:0] x, input logic [5:0] d);
        iso = o;
        idx = x;
        dat = d;
        we = 1'b1;
        @(negedge clk) we = 1'b0;
    endtask : wr
    task automatic note(input int i, input logic v);
        q.push_back('{i, v});
    endtask : note
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_of_test
    // Take each note off the queue and compare with settled outputs
    always @(negedge clk) begin
        while (q.size() > 0) begin
            n = q.pop_front();
            cmp_count++;
            if (allo[n.i] !== n.v) begin
                bad_count++;
                $display("Error out bit %0d exp %b got %b", n.i, n.v,
                         allo[n.i]);
            end
        end
    end
    // Hang guard, far beyond the hundred or so cycles needed
    initial begin
        repeat (1000) @(posedge clk);
        bad_count++;
        end_of_test();
    end
    initial begin
        repeat (5) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        lat = 24'($random(seed));
        per = {$random(seed), $random(seed)};
        // Same code table on every pin, all pins driving
        for (int p = 0; p < 24; p++) begin
            c = cd[p % 4];
            wr(1'b1, 6'(p), c);
            e[p] = c == 6'h00 ? lat[p] : per[c];
            @(posedge clk);
            note(p, e[p]);
            @(negedge clk);
        end
        repeat (3) @(posedge clk);
        for (int p = 0; p < 24; p++) begin
            note(24 + p, 1'b0);
            note(48 + p, e[p]);
        end
        $display("output select test done");
        @(negedge clk) dir = 24'hffffff;
        // Input select per port field, port code 3 routes nothing
        for (int t = 0; t < 8; t++) begin
            c = {1'b0, 2'(t % 4), 3'($random(seed))};
            wr(1'b0, 6'h05, c);
            ext = 24'($random(seed));
            b = c[4:3] == 2'h3 ? 1'b0 : ext[c[4:3] * 8 + c[2:0]];
            repeat (3) @(posedge clk);
            note(77, b);
            @(negedge clk);
        end
        $display("input select test done");
        // Serial sync and I2C take the pin enables
        for (int m = 0; m < 4; m++) begin
            {i2c, ss} = 2'(m);
            {sda, dt, scl, ck} = 4'($random(seed));
            @(posedge clk);
            note(36, i2c ? !sda : 1'b1);
            note(38, i2c ? !scl : 1'b1);
            note(37, ss ? !dt : 1'b1);
            note(39, ss ? !ck : 1'b1);
            @(negedge clk);
        end
        $display("override test done");
        // Select write to input 34 also moves the receive input 35 that shares it
        {i2c, ss} = 2'h0;
        wr(1'b0, 6'h22, 6'h02);
        repeat (3) @(posedge clk);
        note(107, ext[2]);
        @(negedge clk);
        $display("shared select test done");
        repeat (2) @(posedge clk);
        end_of_test();
    end
endmodule : tb
bind pps_mux pps_mux_chk chk_u (.I_CLK, .I_RST, .I_CFG_WE, .I_CFG_IS_OUT,
    .I_CFG_IDX, .I_CFG_DATA, .I_PIN, .I_LAT, .I_DIR_IN, .I_PERIPH_OUT,
    .I_SERIAL_SYNC, .I_SERIAL_DT_OE, .I_SYNC_I2C, .I_I2C_SDA_LOW,
    .O_PIN_OUT, .O_PIN_OE_N, .O_PORT_READ, .O_PERIPH_IN);
